// ### src/tfr_cfg.svh
// Command codes, field positions, reset values and timing counts of the temperature fault block.
`ifndef TFR_CFG_SVH
`define TFR_CFG_SVH

// ----------------------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------------------
`define TFR_CMD_CLEAR_FAULTS 8'h03
`define TFR_CMD_EXT_OT_RESP 8'h50
`define TFR_CMD_EXT_UT_RESP 8'h54
`define TFR_CMD_INT_OT_RESP 8'hd6

// ----------------------------------------------------------------------------
// Response byte fields and reset values
// ----------------------------------------------------------------------------
`define TFR_RESP_HI 7
`define TFR_RESP_LO 6
`define TFR_RETRY_HI 5
`define TFR_RETRY_LO 3
`define TFR_RESP_CONTINUE 2'h0
`define TFR_RESP_SHUTDOWN 2'h2
`define TFR_RESP_WHILE_PRESENT 2'h3
`define TFR_RETRY_NONE 3'h0
`define TFR_RETRY_FOREVER 3'h7
`define TFR_EXT_RESP_RESET 8'hb8
`define TFR_INT_RESP_RESET 8'hc0

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define TFR_CLOCK_HZ 40000000
`define TFR_ADC_PERIOD_MS 120
`define TFR_ADC_PERIOD_CYCLES ((`TFR_CLOCK_HZ / 1000) * `TFR_ADC_PERIOD_MS)

`endif

// ### src/tfr_pkg.sv
// Types shared by the temperature fault response block.
`default_nettype none

package tfr_pkg;

  typedef struct packed {
    logic valid;
    logic write;
    logic page;
    logic [7:0] code;
    logic [7:0] data;
  } tfr_cmd_t;

  typedef struct packed {
    logic vendor_summary_bit;
    logic int_ot;
    logic temperature;
    logic ext_ot;
    logic ext_ut;
  } tfr_status_t;

  typedef struct packed {
    logic int_ot;
    logic ext_ot;
    logic ext_ut;
  } tfr_mask_t;

  typedef enum logic [1:0] {
    TFR_RUNNING,
    TFR_LATCHED,
    TFR_RETRY_WAIT
  } tfr_ext_state_t;

endpackage : tfr_pkg

`default_nettype wire

// ### src/tfr_fault_response.sv
// Temperature fault response logic for two paged output channels.
`include "tfr_cfg.svh"
`default_nettype none

module tfr_fault_response #(
  parameter int unsigned ADC_PERIOD_CYCLES = `TFR_ADC_PERIOD_CYCLES
) (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_ce,
  input wire tfr_pkg::tfr_cmd_t i_cmd,
  input wire logic i_int_ot_fault,
  input wire logic [1:0] i_ext_ot_fault,
  input wire logic [1:0] i_ext_ut_fault,
  input wire logic [1:0] i_channel_run_pin,
  input wire tfr_pkg::tfr_mask_t i_alert_mask,
  input wire logic [15:0] i_retry_interval_setting,
  output logic [7:0] o_rd_data,
  output logic o_rd_valid,
  output logic o_comm_mem_logic_fault,
  output logic o_alert_n,
  output logic [1:0] o_output_en,
  output tfr_pkg::tfr_status_t [1:0] o_status
);

  // --------------------------------------------------------------------------
  // Setting validation
  // --------------------------------------------------------------------------
  function automatic logic int_resp_ok(input logic [7:0] v);
    int_resp_ok = (v[`TFR_RESP_HI:`TFR_RESP_LO] == `TFR_RESP_SHUTDOWN ||
                   v[`TFR_RESP_HI:`TFR_RESP_LO] == `TFR_RESP_WHILE_PRESENT) &&
                  (v[`TFR_RETRY_HI:`TFR_RETRY_LO] == `TFR_RETRY_NONE);
  endfunction : int_resp_ok

  function automatic logic ext_resp_ok(input logic [7:0] v);
    ext_resp_ok = v[`TFR_RESP_HI:`TFR_RESP_LO] == `TFR_RESP_CONTINUE ||
                  v[`TFR_RESP_HI:`TFR_RESP_LO] == `TFR_RESP_SHUTDOWN;
  endfunction : ext_resp_ok

  // --------------------------------------------------------------------------
  // Command decode
  // --------------------------------------------------------------------------
  logic wr;
  logic rd;
  logic clear_cmd;
  logic wr_int;
  logic wr_ext_ot;
  logic wr_ext_ut;
  logic bad_write;
  logic [7:0] int_resp_q;
  logic [7:0] ext_ot_resp_q [2];
  logic [7:0] ext_ut_resp_q [2];

  assign wr = i_cmd.valid && i_cmd.write;
  assign rd = i_cmd.valid && !i_cmd.write;
  assign clear_cmd = wr && i_cmd.code == `TFR_CMD_CLEAR_FAULTS;
  assign wr_int = wr && i_cmd.code == `TFR_CMD_INT_OT_RESP;
  assign wr_ext_ot = wr && i_cmd.code == `TFR_CMD_EXT_OT_RESP;
  assign wr_ext_ut = wr && i_cmd.code == `TFR_CMD_EXT_UT_RESP;
  // Unknown write codes are also refused, so software sees a wrong command at once.
  assign bad_write = (wr_int && !int_resp_ok(i_cmd.data)) ||
                     ((wr_ext_ot || wr_ext_ut) && !ext_resp_ok(i_cmd.data)) ||
                     (wr && !clear_cmd && !wr_int && !wr_ext_ot && !wr_ext_ut);

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      int_resp_q <= `TFR_INT_RESP_RESET;
    end else if (i_ce && wr_int && int_resp_ok(i_cmd.data)) begin
      int_resp_q <= i_cmd.data;
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_comm_mem_logic_fault <= 1'b0;
    end else if (i_ce) begin
      if (bad_write) begin
        o_comm_mem_logic_fault <= 1'b1;
      end else if (clear_cmd) begin
        o_comm_mem_logic_fault <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rd_data <= 8'h00;
      o_rd_valid <= 1'b0;
    end else if (i_ce) begin
      o_rd_valid <= rd;
      case (i_cmd.code)
        `TFR_CMD_INT_OT_RESP: o_rd_data <= int_resp_q;
        `TFR_CMD_EXT_OT_RESP: o_rd_data <= ext_ot_resp_q[i_cmd.page];
        `TFR_CMD_EXT_UT_RESP: o_rd_data <= ext_ut_resp_q[i_cmd.page];
        default: o_rd_data <= 8'h00;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Conversion tick for the external sensors
  // --------------------------------------------------------------------------
  // External faults are only seen on the conversion tick, which both channels share.
  logic [31:0] adc_cnt_q;
  logic adc_tick;
  assign adc_tick = adc_cnt_q == 32'(ADC_PERIOD_CYCLES - 1);

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      adc_cnt_q <= 32'h0;
    end else if (i_ce) begin
      adc_cnt_q <= adc_tick ? 32'h0 : adc_cnt_q + 32'h1;
    end
  end

  // --------------------------------------------------------------------------
  // Per-channel response
  // --------------------------------------------------------------------------
  // Delay bits 2:0 of the internal setting are never decoded.
  logic [1:0] int_resp;
  logic [1:0] chan_alert;
  assign int_resp = int_resp_q[`TFR_RESP_HI:`TFR_RESP_LO];

  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    logic run_q;
    logic run_on;
    logic run_rise;
    logic clear;
    logic ot_seen;
    logic ut_seen;
    logic ext_hit;
    logic [7:0] ext_sel;
    logic int_latch_q;
    logic [15:0] retry_cnt_q;
    tfr_pkg::tfr_ext_state_t ext_state_q;
    tfr_pkg::tfr_status_t st_q;

    assign run_on = i_channel_run_pin[ch];
    assign run_rise = run_on && !run_q;
    assign clear = clear_cmd || run_rise;
    assign ot_seen = adc_tick && i_ext_ot_fault[ch];
    assign ut_seen = adc_tick && i_ext_ut_fault[ch];
    // An overtemperature takes precedence when both fire in one conversion.
    assign ext_sel = ot_seen ? ext_ot_resp_q[ch] : ext_ut_resp_q[ch];
    assign ext_hit = (ot_seen || ut_seen) &&
                     ext_sel[`TFR_RESP_HI:`TFR_RESP_LO] == `TFR_RESP_SHUTDOWN;

    always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
        run_q <= 1'b0;
      end else if (i_ce) begin
        run_q <= run_on;
      end
    end

    always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
        ext_ot_resp_q[ch] <= `TFR_EXT_RESP_RESET;
        ext_ut_resp_q[ch] <= `TFR_EXT_RESP_RESET;
      end else if (i_ce && i_cmd.page == 1'(ch) && ext_resp_ok(i_cmd.data)) begin
        if (wr_ext_ot) begin
          ext_ot_resp_q[ch] <= i_cmd.data;
        end
        if (wr_ext_ut) begin
          ext_ut_resp_q[ch] <= i_cmd.data;
        end
      end
    end

    // Set wins over clear so a fault in the clearing cycle is kept.
    always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
        st_q <= '0;
      end else if (i_ce) begin
        st_q.vendor_summary_bit <= i_int_ot_fault || (st_q.vendor_summary_bit && !clear);
        st_q.int_ot <= i_int_ot_fault || (st_q.int_ot && !clear);
        st_q.temperature <= ot_seen || ut_seen || (st_q.temperature && !clear);
        st_q.ext_ot <= ot_seen || (st_q.ext_ot && !clear);
        st_q.ext_ut <= ut_seen || (st_q.ext_ut && !clear);
      end
    end

    always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
        int_latch_q <= 1'b0;
      end else if (i_ce) begin
        if (i_int_ot_fault && int_resp == `TFR_RESP_SHUTDOWN) begin
          int_latch_q <= 1'b1;
        end else if (clear) begin
          int_latch_q <= 1'b0;
        end
      end
    end

    always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
        ext_state_q <= tfr_pkg::TFR_RUNNING;
        retry_cnt_q <= 16'h0;
      end else if (i_ce) begin
        case (ext_state_q)
          tfr_pkg::TFR_RUNNING: begin
            if (ext_hit) begin
              retry_cnt_q <= 16'h0;
              if (ext_sel[`TFR_RETRY_HI:`TFR_RETRY_LO] == `TFR_RETRY_FOREVER) begin
                ext_state_q <= tfr_pkg::TFR_RETRY_WAIT;
              end else begin
                ext_state_q <= tfr_pkg::TFR_LATCHED;
              end
            end
          end
          tfr_pkg::TFR_LATCHED: begin
            if (!run_on) begin
              ext_state_q <= tfr_pkg::TFR_RUNNING;
            end
          end
          tfr_pkg::TFR_RETRY_WAIT: begin
            if (!run_on || retry_cnt_q >= i_retry_interval_setting) begin
              ext_state_q <= tfr_pkg::TFR_RUNNING;
            end else begin
              retry_cnt_q <= retry_cnt_q + 16'h1;
            end
          end
          default: ext_state_q <= tfr_pkg::TFR_RUNNING;
        endcase
      end
    end

    always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
        o_output_en[ch] <= 1'b0;
      end else if (i_ce) begin
        o_output_en[ch] <= run_on && !int_latch_q && !ext_hit &&
                           !(i_int_ot_fault && int_resp != 2'h0) &&
                           ext_state_q == tfr_pkg::TFR_RUNNING;
      end
    end

    assign chan_alert[ch] = (st_q.int_ot && !i_alert_mask.int_ot) ||
                            (st_q.ext_ot && !i_alert_mask.ext_ot) ||
                            (st_q.ext_ut && !i_alert_mask.ext_ut);
    assign o_status[ch] = st_q;
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_alert_n <= 1'b1;
    end else if (i_ce) begin
      o_alert_n <= !(|chan_alert);
    end
  end

endmodule : tfr_fault_response

`default_nettype wire

// ### testbench/tfr_fault_response_properties.sv
// Port-level checks of the temperature fault response block.
`default_nettype none
module tfr_fault_response_properties #(
  parameter int unsigned ADC_PERIOD_CYCLES = 16
) (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_ce,
  input wire tfr_pkg::tfr_cmd_t i_cmd,
  input wire logic i_int_ot_fault,
  input wire logic [1:0] i_ext_ot_fault,
  input wire logic [1:0] i_channel_run_pin,
  input wire tfr_pkg::tfr_mask_t i_alert_mask,
  input wire logic o_rd_valid,
  input wire logic o_comm_mem_logic_fault,
  input wire logic o_alert_n,
  input wire logic [1:0] o_output_en,
  input wire tfr_pkg::tfr_status_t [1:0] o_status
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] wait_q;
  logic [7:0] wr_code;
  assign wr_code = (i_cmd.valid && i_cmd.write && i_ce) ? i_cmd.code : 8'h00;
  // -------------------------------------------
  // Helper logic
  // -------------------------------------------
  // Detection waits for a conversion tick, so only the length of the wait is bounded.
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      wait_q <= 32'h0;
    end else if (i_ext_ot_fault[0] && !o_status[0].ext_ot) begin
      wait_q <= wait_q + 32'h1;
    end else begin
      wait_q <= 32'h0;
    end
  end
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_nrst);
  sequence s_int_seen;
    i_int_ot_fault && i_ce ##1 o_status[0].int_ot;
  endsequence
  property p_int_status;
    i_int_ot_fault && i_ce |=> o_status[0].int_ot && o_status[1].vendor_summary_bit;
  endproperty
  property p_int_alert;
    (!i_alert_mask.int_ot throughout s_int_seen) |=> !o_alert_n;
  endproperty
  property p_sticky;
    o_status[0].ext_ot && i_ce && wr_code != 8'h03 && i_channel_run_pin[0]
      && $past(i_channel_run_pin[0]) && $past(i_channel_run_pin[0], 2) |=> o_status[0].ext_ot;
  endproperty
  property p_int_bad;
    wr_code == 8'hd6 && (i_cmd.data[7:6] < 2'h2 || i_cmd.data[5:3] != 3'h0)
      |=> o_comm_mem_logic_fault;
  endproperty
  property p_ext_bad;
    (wr_code == 8'h50 || wr_code == 8'h54) && i_cmd.data[6] |=> o_comm_mem_logic_fault;
  endproperty
  property p_int_off;
    i_int_ot_fault && i_ce |=> o_output_en == 2'h0;
  endproperty
  property p_rd_answer;
    i_cmd.valid && !i_cmd.write && i_ce |=> o_rd_valid;
  endproperty
  property p_ext_wait;
    wait_q <= 32'(ADC_PERIOD_CYCLES) + 32'h2;
  endproperty
  a_int_status: assert property (p_int_status)
    else $error("internal fault status missing");
  a_int_alert: assert property (p_int_alert)
    else $error("alert missing");
  a_sticky: assert property (p_sticky)
    else $error("status bit dropped");
  a_int_bad: assert property (p_int_bad)
    else $error("logic fault missing on internal setting");
  a_ext_bad: assert property (p_ext_bad)
    else $error("logic fault missing on external setting");
  a_int_off: assert property (p_int_off)
    else $error("output not disabled");
  a_rd_answer: assert property (p_rd_answer)
    else $error("read answer missing");
  a_ext_wait: assert property (p_ext_wait)
    else $error("external fault not flagged in time");
endmodule : tfr_fault_response_properties
`default_nettype wire

// ### testbench/tfr_host_model.sv
// Bus host model that issues one-byte commands to the fault block.
`default_nettype none
module tfr_host_model (
  input wire logic i_clock,
  input wire logic i_rd_valid,
  input wire logic [7:0] i_rd_data,
  output var tfr_pkg::tfr_cmd_t o_cmd
);
  timeunit 1ns;
  timeprecision 100ps;
  initial o_cmd = '0;
  // The extra edge after release keeps back-to-back commands from colliding.
  task automatic xfer(input logic wr, input logic pg, input logic [7:0] code,
                      input logic [7:0] wd, output logic [7:0] rd);
    int n;
    n = 0;
    o_cmd <= '{1'b1, wr, pg, code, wd};
    @(posedge i_clock);
    o_cmd <= '0;
    do begin
      @(posedge i_clock);
      n++;
    end while (!wr && i_rd_valid !== 1'b1 && n < 4);
    rd = i_rd_data;
  endtask : xfer
endmodule : tfr_host_model
`default_nettype wire

// ### testbench/tfr_fault_response_tb.sv
// Self-checking bench for the temperature fault response block.
`default_nettype none
module tfr_fault_response_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int ADC = 16;
  logic i_clock = 1'b0;
  logic i_nrst = 1'b0;
  logic i_ce = 1'b1;
  logic i_int_ot_fault = 1'b0;
  logic [1:0] i_ext_ot_fault = 2'h0;
  logic [1:0] i_ext_ut_fault = 2'h0;
  logic [1:0] i_channel_run_pin = 2'h0;
  tfr_pkg::tfr_mask_t i_alert_mask = '0;
  tfr_pkg::tfr_cmd_t cmd;
  logic [7:0] o_rd_data;
  logic [7:0] rd;
  logic o_rd_valid, o_comm_mem_logic_fault, o_alert_n;
  logic [1:0] o_output_en;
  tfr_pkg::tfr_status_t [1:0] o_status;
  logic [15:0] bad [7] = '{16'h5040, 16'h50c0, 16'h5478, 16'hd600, 16'hd640, 16'hd6c8, 16'hd6f8};
  int n_mismatch = 0;
  int samples_checked = 0;
  always #12.5 i_clock = ~i_clock;
  tfr_fault_response #(.ADC_PERIOD_CYCLES(ADC)) tfr_fault_response_i (
    .i_clock(i_clock), .i_nrst(i_nrst), .i_ce(i_ce), .i_cmd(cmd),
    .i_int_ot_fault(i_int_ot_fault), .i_ext_ot_fault(i_ext_ot_fault),
    .i_ext_ut_fault(i_ext_ut_fault), .i_channel_run_pin(i_channel_run_pin),
    .i_alert_mask(i_alert_mask), .i_retry_interval_setting(16'h0008),
    .o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid),
    .o_comm_mem_logic_fault(o_comm_mem_logic_fault), .o_alert_n(o_alert_n),
    .o_output_en(o_output_en), .o_status(o_status));
  tfr_host_model tfr_host_model_i (.i_clock(i_clock), .i_rd_valid(o_rd_valid),
    .i_rd_data(o_rd_data), .o_cmd(cmd));
  // -------------------------------------------
  // Tasks
  // -------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic st(input logic [4:0] e0, input logic [4:0] e1);
    chk({3'h0, o_status[0]}, {3'h0, e0});
    chk({3'h0, o_status[1]}, {3'h0, e1});
  endtask : st
  task automatic cy(input int n);
    repeat (n) @(posedge i_clock);
  endtask : cy
  task automatic wr(input logic pg, input logic [7:0] code, input logic [7:0] d);
    tfr_host_model_i.xfer(1'b1, pg, code, d, rd);
  endtask : wr
  task automatic rdchk(input logic pg, input logic [7:0] code, input logic [7:0] exp);
    tfr_host_model_i.xfer(1'b0, pg, code, 8'h00, rd);
    chk(8'(o_rd_valid), 8'h01);
    chk(rd, exp);
  endtask : rdchk
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : give_verdict
  // The whole sequence needs a few hundred cycles, so this limit only trips on a hang.
  initial begin
    cy(3000);
    n_mismatch++;
    give_verdict();
  end
  initial begin
    cy(16);
    i_nrst <= 1'b1;
    cy(1);
    rdchk(0, 8'h50, 8'hb8);
    rdchk(1, 8'h54, 8'hb8);
    wr(1, 8'h50, 8'h38);
    rdchk(1, 8'h50, 8'h38);
    rdchk(0, 8'h50, 8'hb8);
    foreach (bad[k]) begin
      wr(0, bad[k][15:8], bad[k][7:0]);
      cy(1);
      chk(8'(o_comm_mem_logic_fault), 8'h01);
      rdchk(0, bad[k][15:8], (bad[k][15:8] == 8'hd6) ? 8'hc0 : 8'hb8);
      wr(0, 8'h03, 8'h00);
      cy(1);
      chk(8'(o_comm_mem_logic_fault), 8'h00);
    end
    wr(0, 8'hd6, 8'hc7);
    cy(1);
    chk(8'(o_comm_mem_logic_fault), 8'h00);
    i_channel_run_pin <= 2'h3;
    cy(3);
    chk(8'(o_output_en), 8'h03);
    i_int_ot_fault <= 1'b1;
    cy(3);
    st(5'h18, 5'h18);
    chk(8'(o_output_en), 8'h00);
    chk(8'(o_alert_n), 8'h00);
    i_int_ot_fault <= 1'b0;
    cy(3);
    chk(8'(o_output_en), 8'h03);
    st(5'h18, 5'h18);
    wr(0, 8'h03, 8'h00);
    cy(3);
    st(5'h00, 5'h00);
    chk(8'(o_alert_n), 8'h01);
    wr(0, 8'hd6, 8'h80);
    i_alert_mask <= 3'h4;
    i_int_ot_fault <= 1'b1;
    cy(3);
    chk(8'(o_alert_n), 8'h01);
    i_int_ot_fault <= 1'b0;
    i_alert_mask <= 3'h0;
    cy(3);
    chk(8'(o_output_en), 8'h00);
    wr(0, 8'h03, 8'h00);
    cy(3);
    chk(8'(o_output_en), 8'h03);
    i_ext_ot_fault <= 2'h1;
    cy(ADC + 3);
    st(5'h06, 5'h00);
    chk(8'(o_output_en), 8'h02);
    chk(8'(o_alert_n), 8'h00);
    i_ext_ot_fault <= 2'h0;
    cy(ADC + 12);
    chk(8'(o_output_en), 8'h03);
    st(5'h06, 5'h00);
    wr(0, 8'h03, 8'h00);
    wr(1, 8'h54, 8'h80);
    i_ext_ut_fault <= 2'h2;
    cy(ADC + 3);
    st(5'h00, 5'h05);
    chk(8'(o_output_en), 8'h01);
    i_ext_ut_fault <= 2'h0;
    cy(ADC + 12);
    chk(8'(o_output_en), 8'h01);
    i_channel_run_pin <= 2'h1;
    cy(3);
    i_channel_run_pin <= 2'h3;
    cy(3);
    chk(8'(o_output_en), 8'h03);
    st(5'h00, 5'h00);
    i_ext_ot_fault <= 2'h2;
    cy(ADC + 3);
    st(5'h00, 5'h06);
    chk(8'(o_output_en), 8'h03);
    // A low clock enable must hold every flop, so the fault is only seen once it rises.
    i_ce <= 1'b0;
    i_int_ot_fault <= 1'b1;
    cy(3);
    st(5'h00, 5'h06);
    chk(8'(o_output_en), 8'h03);
    i_ce <= 1'b1;
    cy(3);
    st(5'h18, 5'h1e);
    chk(8'(o_output_en), 8'h00);
    give_verdict();
  end
endmodule : tfr_fault_response_tb
bind tfr_fault_response tfr_fault_response_properties #(.ADC_PERIOD_CYCLES(ADC_PERIOD_CYCLES))
  tfr_fault_response_properties_i (.i_clock(i_clock), .i_nrst(i_nrst), .i_ce(i_ce),
  .i_cmd(i_cmd), .i_int_ot_fault(i_int_ot_fault), .i_ext_ot_fault(i_ext_ot_fault),
  .i_channel_run_pin(i_channel_run_pin), .i_alert_mask(i_alert_mask), .o_rd_valid(o_rd_valid),
  .o_comm_mem_logic_fault(o_comm_mem_logic_fault), .o_alert_n(o_alert_n),
  .o_output_en(o_output_en), .o_status(o_status));
`default_nettype wire
